// *** design/ofprt_cfg.svh ***
`ifndef OFPRT_CFG_SVH
`define OFPRT_CFG_SVH

`define OFPRT_SYS_CLK_NS 100
`define OFPRT_WIN_TIME_NS 300
`define OFPRT_WIN_CYCLES ((`OFPRT_WIN_TIME_NS + `OFPRT_SYS_CLK_NS - 1) / `OFPRT_SYS_CLK_NS)
`define OFPRT_POLL_GAP_NS 1000
`define OFPRT_POLL_CYCLES ((`OFPRT_POLL_GAP_NS + `OFPRT_SYS_CLK_NS - 1) / `OFPRT_SYS_CLK_NS)
`define OFPRT_PAD_BYTES 8'h01
`define OFPRT_DATA_RESET 8'h00

`endif

// *** design/ofprt_pkg.sv ***
package ofprt_pkg;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_DELAY,
        RD_OPEN,
        RD_DONE
    } ofprt_rd_state_t;

    typedef enum logic [1:0] {
        PL_IDLE,
        PL_WAIT,
        PL_ASK,
        PL_CHECK
    } ofprt_poll_state_t;

endpackage

// *** design/ofprt_read_tuning.sv ***
`timescale 1ns/1ns
`include "ofprt_cfg.svh"

module ofprt_read_tuning #(
    parameter int DATA_W = 8,
    parameter int DELAY_W = 4,
    parameter int LEN_W = 8,
    parameter int WIN_CYCLES = `OFPRT_WIN_CYCLES,
    parameter int POLL_CYCLES = `OFPRT_POLL_CYCLES
) (
    input wire logic sys_clk,                   // System clock, 10 MHz
    input wire logic reset_n,                   // Asynchronous reset, active low
    input wire logic phy_enable,                // PHY module in use
    input wire logic pipeline_mode,             // PHY pipeline mode setting
    input wire logic [DELAY_W-1:0] read_delay,  // Window delay in cycles
    input wire logic read_start,                // Pulse: begin a read
    input wire logic [LEN_W-1:0] read_len,      // Bytes wanted by the requester
    input wire logic sw_command_read,           // Read comes from software_command_path
    input wire logic flash_dqs,                 // Data strobe from flash
    input wire logic [DATA_W-1:0] flash_data,   // Read data from flash
    input wire logic launch_sample,             // Own capture tick, PHY off
    input wire logic auto_poll_enable,          // Automatic busy polling wanted
    input wire logic write_done,                // Pulse: page program issued
    input wire logic status_valid,              // Pulse: status byte returned
    input wire logic status_busy,               // Busy bit of returned status
    output logic [DATA_W-1:0] rd_data,          // Captured byte
    output logic rd_valid,                      // Pulse: rd_data is new
    output logic rd_done,                       // Pulse: read finished
    output logic rd_busy,                       // Read in progress
    output logic [LEN_W-1:0] rd_total,          // Bytes asked of the flash
    output logic capture_miss,                  // Sticky: strobe before window or window expired unstrobed, PHY on
    output logic pipeline_misuse,               // Sticky: read under delay without pipeline
    output logic auto_poll_active,              // Automatic polling allowed now
    output logic poll_request,                  // Pulse: issue a status read
    output logic poll_done                      // Pulse: flash no longer busy
);

    ofprt_pkg::ofprt_rd_state_t rd_state;
    ofprt_pkg::ofprt_poll_state_t pl_state;
    logic [DELAY_W-1:0] delay_lat;
    logic [DELAY_W-1:0] delay_cnt;
    logic [7:0] win_cnt;
    logic [LEN_W-1:0] remain;
    logic phy_lat;
    logic dqs_q;
    logic [15:0] poll_cnt;
    logic dqs_edge;
    logic capture;
    logic miss_event;
    logic delay_scheme;

    assign dqs_edge = flash_dqs & ~dqs_q;
    // Strobe only counts while the window is open
    assign capture = phy_lat ? (rd_state == ofprt_pkg::RD_OPEN) && dqs_edge
                             : (rd_state == ofprt_pkg::RD_OPEN) && launch_sample;
    assign miss_event = phy_lat && dqs_edge && (rd_state == ofprt_pkg::RD_DELAY);
    assign delay_scheme = phy_enable && (read_delay != '0);
    assign auto_poll_active = auto_poll_enable && !delay_scheme;
    assign rd_busy = (rd_state != ofprt_pkg::RD_IDLE);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dqs_q <= 1'b0;
        end else begin
            dqs_q <= flash_dqs;
        end
    end

    // Delay and mode are frozen per read; changes mid read would split the eye
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            delay_lat <= '0;
            phy_lat <= 1'b0;
            rd_total <= '0;
        end else if (read_start && rd_state == ofprt_pkg::RD_IDLE) begin
            delay_lat <= read_delay;
            phy_lat <= phy_enable;
            if (sw_command_read) begin
                rd_total <= read_len + LEN_W'(`OFPRT_PAD_BYTES);
            end else begin
                rd_total <= read_len;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_state <= ofprt_pkg::RD_IDLE;
            delay_cnt <= '0;
            win_cnt <= 8'h00;
            remain <= '0;
        end else begin
            case (rd_state)
                ofprt_pkg::RD_IDLE: begin
                    if (read_start) begin
                        remain <= sw_command_read ?
                                  read_len + LEN_W'(`OFPRT_PAD_BYTES) : read_len;
                        delay_cnt <= read_delay;
                        rd_state <= (read_len == '0 && !sw_command_read) ?
                                    ofprt_pkg::RD_DONE : ofprt_pkg::RD_DELAY;
                    end
                end
                ofprt_pkg::RD_DELAY: begin
                    // Each extra delay count shifts the window one cycle later
                    if (delay_cnt == '0) begin
                        win_cnt <= 8'(WIN_CYCLES);
                        rd_state <= ofprt_pkg::RD_OPEN;
                    end else begin
                        delay_cnt <= delay_cnt - DELAY_W'(1);
                    end
                end
                ofprt_pkg::RD_OPEN: begin
                    if (capture || win_cnt == 8'h01) begin
                        // Window re-arms per byte; a missed byte still counts down
                        delay_cnt <= delay_lat;
                        remain <= remain - LEN_W'(1);
                        rd_state <= (remain == LEN_W'(1)) ?
                                    ofprt_pkg::RD_DONE : ofprt_pkg::RD_DELAY;
                    end else begin
                        win_cnt <= win_cnt - 8'h01;
                    end
                end
                ofprt_pkg::RD_DONE: begin
                    rd_state <= ofprt_pkg::RD_IDLE;
                end
                default: begin
                    rd_state <= ofprt_pkg::RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= DATA_W'(`OFPRT_DATA_RESET);
            rd_valid <= 1'b0;
            rd_done <= 1'b0;
        end else begin
            rd_valid <= capture;
            rd_done <= (rd_state == ofprt_pkg::RD_DONE);
            if (capture) begin
                rd_data <= flash_data;
            end
        end
    end

    // Window expiry with no strobe is a miss as well; set beats clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_miss <= 1'b0;
        end else if (miss_event || (phy_lat && rd_state == ofprt_pkg::RD_OPEN
                                    && !capture && win_cnt == 8'h01)) begin
            capture_miss <= 1'b1;
        end else if (read_start && rd_state == ofprt_pkg::RD_IDLE) begin
            capture_miss <= 1'b0;
        end
    end

    // Flags host sequencing slips; the device still performs the read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pipeline_misuse <= 1'b0;
        end else if (read_start && rd_state == ofprt_pkg::RD_IDLE
                     && delay_scheme && !pipeline_mode) begin
            pipeline_misuse <= 1'b1;
        end else if (read_start && rd_state == ofprt_pkg::RD_IDLE) begin
            pipeline_misuse <= 1'b0;
        end
    end

    // Automatic busy polling; dropped at once if the delay scheme comes on
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pl_state <= ofprt_pkg::PL_IDLE;
            poll_cnt <= 16'h0000;
            poll_request <= 1'b0;
            poll_done <= 1'b0;
        end else begin
            poll_request <= 1'b0;
            poll_done <= 1'b0;
            if (!auto_poll_active) begin
                pl_state <= ofprt_pkg::PL_IDLE;
            end else begin
                case (pl_state)
                    ofprt_pkg::PL_IDLE: begin
                        if (write_done) begin
                            poll_cnt <= 16'(POLL_CYCLES);
                            pl_state <= ofprt_pkg::PL_WAIT;
                        end
                    end
                    ofprt_pkg::PL_WAIT: begin
                        if (poll_cnt <= 16'h0001) begin
                            pl_state <= ofprt_pkg::PL_ASK;
                        end else begin
                            poll_cnt <= poll_cnt - 16'h0001;
                        end
                    end
                    ofprt_pkg::PL_ASK: begin
                        poll_request <= 1'b1;
                        pl_state <= ofprt_pkg::PL_CHECK;
                    end
                    ofprt_pkg::PL_CHECK: begin
                        if (status_valid && status_busy) begin
                            poll_cnt <= 16'(POLL_CYCLES);
                            pl_state <= ofprt_pkg::PL_WAIT;
                        end else if (status_valid) begin
                            poll_done <= 1'b1;
                            pl_state <= ofprt_pkg::PL_IDLE;
                        end
                    end
                    default: begin
                        pl_state <= ofprt_pkg::PL_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// *** tb/ofprt_read_tuning_asserts.sv ***
`timescale 1ns/1ns
module ofprt_read_tuning_chk #(parameter int DELAY_W = 4, parameter int LEN_W = 8) (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic phy_enable, // PHY
    input wire logic [DELAY_W-1:0] read_delay, // Delay
    input wire logic read_start, // Start
    input wire logic [LEN_W-1:0] read_len, // Length
    input wire logic sw_command_read, // Pad
    input wire logic auto_poll_enable, // Poll on
    input wire logic status_valid, // Reply
    input wire logic status_busy, // Busy bit
    input wire logic rd_valid, // Byte
    input wire logic rd_busy, // Reading
    input wire logic [LEN_W-1:0] rd_total, // Total
    input wire logic capture_miss, // Miss
    input wire logic auto_poll_active, // Poll ok
    input wire logic poll_request, // Ask
    input wire logic poll_done // Done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic take;
    assign take = read_start && !rd_busy;
    chk_start_busy: assert property (take |=> rd_busy)
        else $error("read not started");
    chk_no_early: assert property (take |=> !rd_valid [*2])
        else $error("byte before window");
    chk_total_pad: assert property (take |=>
        rd_total == $past(read_len) + LEN_W'($past(sw_command_read)))
        else $error("total wrong");
    chk_valid_gap: assert property (rd_valid |=> !rd_valid)
        else $error("byte pulse too long");
    chk_miss_hold: assert property (capture_miss && !take |=> capture_miss)
        else $error("miss flag lost");
    chk_poll_gate: assert property (auto_poll_active ==
        (auto_poll_enable && !(phy_enable && read_delay != 0)))
        else $error("poll gate wrong");
    chk_ask_gated: assert property (poll_request |-> $past(auto_poll_active))
        else $error("poll asked while off");
    chk_done_cause: assert property (poll_done |-> $past(status_valid && !status_busy))
        else $error("poll done without idle status");
    cover property (take && phy_enable);
    cover property (capture_miss);
    cover property (poll_done);
endmodule
bind ofprt_read_tuning ofprt_read_tuning_chk #(.DELAY_W(DELAY_W), .LEN_W(LEN_W))
    ofprt_read_tuning_chk_i (.*);

// *** tb/ofprt_flash_model.sv ***
`timescale 1ns/1ns
module ofprt_flash_model (
    input wire logic sys_clk, // Clock
    input wire logic rd_busy, // Read on
    input wire logic [3:0] lag, // Strobe slot
    input wire logic [7:0] byte_val, // Byte
    input wire logic poll_request, // Ask
    input wire logic [3:0] busy_cnt, // Busy replies
    output logic flash_dqs = 0, // Strobe
    output logic [7:0] flash_data = 8'h00, // Data
    output logic status_valid = 0, // Reply
    output logic status_busy = 0 // Busy bit
);
    int cnt = 0;
    int n = 0;
    // Data inverted off the strobe, so a stale byte never matches
    always @(negedge sys_clk) begin
        cnt <= rd_busy ? cnt + 1 : 0;
        // Strobe seen at edge lag+2 after the start edge; lag 0 meets a zero-delay window
        flash_dqs <= rd_busy && cnt == lag + 1;
        flash_data <= (rd_busy && cnt == lag + 1) ? byte_val : ~byte_val;
        status_valid <= poll_request;
        status_busy <= poll_request && n < busy_cnt;
        n <= n + poll_request;
    end
endmodule

// *** tb/ofprt_read_tuning_bench.sv ***
`timescale 1ns/1ns
module ofprt_read_tuning_bench;
    logic sys_clk = 0, reset_n = 0, phy_enable = 0, pipeline_mode = 0, read_start = 0;
    logic sw_command_read = 0, auto_poll_enable = 0, write_done = 0, launch_sample = 0;
    logic rd_valid, rd_done, rd_busy, capture_miss, pipeline_misuse, auto_poll_active;
    logic poll_request, poll_done, flash_dqs, status_valid, status_busy;
    logic [3:0] read_delay = 0, lag = 0, busy_cnt = 0;
    logic [7:0] read_len = 0, byte_val = 0, flash_data, rd_data, rd_total, got;
    int error_cnt = 0, tests_run = 0, cyc = 0, asks = 0;
    always #50 sys_clk = ~sys_clk;
    ofprt_read_tuning ofprt_read_tuning_i (.*);
    ofprt_flash_model ofprt_flash_model_i (.*);
    task check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task rd(input logic phy, pipe, sw, input logic [3:0] d, l, input logic [7:0] len, b);
        {phy_enable, pipeline_mode, sw_command_read, read_delay} = {phy, pipe, sw, d};
        {lag, read_len, byte_val, read_start} = {l, len, b, 1'b1};
        got = ~b;
        @(negedge sys_clk) read_start = 0;
        for (int i = 0; i < 60 && rd_done !== 1'b1; i++) begin
            @(negedge sys_clk);
            if (rd_valid === 1'b1) got = rd_data;
        end
        @(negedge sys_clk);
    endtask
    task t_strobe;
        rd(1, 1, 0, 0, 0, 1, 8'hA5);
        check("rd_data", 8'hA5, got);
        check("rd_total", 8'h01, rd_total);
        check("capture_miss", 8'h00, 8'(capture_miss));
    endtask
    task t_late;
        rd(1, 0, 0, 3, 3, 1, 8'h5A);
        check("late rd_data", 8'h5A, got);
        check("pipeline_misuse", 8'h01, 8'(pipeline_misuse));
    endtask
    task t_early;
        rd(1, 1, 0, 3, 1, 1, 8'h3C);
        check("early rd_data", 8'hC3, got);
        check("capture_miss", 8'h01, 8'(capture_miss));
        check("pipeline_misuse", 8'h00, 8'(pipeline_misuse));
    endtask
    task t_pad;
        rd(1, 1, 1, 0, 0, 2, 8'h11);
        check("pad rd_total", 8'h03, rd_total);
    endtask
    // Delay sweep at a fixed strobe slot; only a too-small delay misses
    task t_tune;
        for (int d = 0; d < 4; d++) begin
            rd(1, 1, 0, 4'(d), 3, 1, 8'h69);
            check("tune capture_miss", 8'(d == 0), 8'(capture_miss));
        end
    endtask
    // PHY off: own tick captures, strobe ignored, no delay scheme
    task t_bypass;
        launch_sample = 1;
        rd(0, 0, 0, 2, 2, 1, 8'h96);
        launch_sample = 0;
        check("bypass rd_data", 8'h96, got);
        check("bypass capture_miss", 8'h00, 8'(capture_miss));
        check("bypass pipeline_misuse", 8'h00, 8'(pipeline_misuse));
    endtask
    task t_reset;
        {phy_enable, pipeline_mode, read_delay, lag, read_len, read_start} =
            {1'b1, 1'b0, 4'h3, 4'h1, 8'h01, 1'b1};
        @(negedge sys_clk) read_start = 0;
        repeat (3) @(negedge sys_clk);
        check("pre-reset capture_miss", 8'h01, 8'(capture_miss));
        check("pre-reset pipeline_misuse", 8'h01, 8'(pipeline_misuse));
        reset_n = 0;
        @(negedge sys_clk) check("reset rd_busy", 8'h00, 8'(rd_busy));
        check("reset capture_miss", 8'h00, 8'(capture_miss));
        check("reset pipeline_misuse", 8'h00, 8'(pipeline_misuse));
        reset_n = 1;
        @(negedge sys_clk);
    endtask
    task t_poll;
        {phy_enable, read_delay, auto_poll_enable, busy_cnt} = {1'b1, 4'h2, 1'b1, 4'h1};
        @(negedge sys_clk) check("poll off", 8'h00, 8'(auto_poll_active));
        {phy_enable, pipeline_mode, write_done} = 3'b001;
        @(negedge sys_clk) write_done = 0;
        for (int i = 0; i < 80 && poll_done !== 1'b1; i++) begin
            @(negedge sys_clk);
            asks += int'(poll_request === 1'b1);
        end
        check("poll_done", 8'h01, 8'(poll_done));
        check("poll asks", 8'h02, 8'(asks));
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        reset_n = 1;
        t_strobe;
        t_late;
        t_early;
        t_pad;
        t_tune;
        t_bypass;
        t_reset;
        t_poll;
        test_done;
    end
    // Whole run needs about 110 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            test_done;
        end
    end
endmodule
